// >>> verilog/context_swap.sv
// Context swap engine with AXI4-Lite control and memory port
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "ctx_swap_map.svh"

module context_swap (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]   awaddr,
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire logic         bready,
  input  wire logic [7:0]   araddr,
  input  wire logic         arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire logic         rready,
  output logic              irq,
  // Swap trigger from the sequencing logic
  input  wire logic         swap_req,
  // Core write port into the operating registers
  input  wire logic         op_we,
  input  wire logic [3:0]   op_word,
  input  wire logic [63:0]  op_wdata,
  // Memory error report
  input  wire logic         err_valid,
  input  wire logic         err_uncorr,
  input  wire logic [7:0]   err_syndrome,
  input  wire logic [1:0]   err_read_mode,
  input  wire logic [21:0]  err_addr,
  // Central memory port
  output logic              mem_req,
  output logic              mem_we,
  output logic [11:0]       mem_addr,
  output logic [63:0]       mem_wdata,
  input  wire logic         mem_ack,
  input  wire logic [63:0]  mem_rdata,
  // Operating registers
  output logic [23:0]       prog_addr,
  output logic [17:0]       base_addr,
  output logic [17:0]       limit_bound,
  output logic [3:0]        mode,
  output logic [7:0]        swap_block_pointer,
  output logic [6:0]        vector_count,
  output logic [8:0]        flags,
  output logic [191:0]      a_regs,
  output logic [511:0]      s_regs,
  output logic              busy,
  output logic              interval_start
);

  ctx_swap_pkg::ctx_state_s s_q;   // Registered state
  ctx_swap_pkg::ctx_state_s s_d;   // Next state
  logic                     start; // Swap request this cycle
  logic [1:0]               ev;    // Interrupt events this cycle
  // State after reset
  function automatic ctx_swap_pkg::ctx_state_s reset_state();
    ctx_swap_pkg::ctx_state_s r;
    r = '0;
    r.fsm = ctx_swap_pkg::ST_IDLE;
    r.awready = 1'b1;
    r.wready = 1'b1;
    r.arready = 1'b1;
    r.irq_stat = `CS_IRQ_RST;
    return r;
  endfunction
  // Merge a write into an old value under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // Build outgoing word idx of the context block
  function automatic logic [63:0] pack_word(
    input ctx_swap_pkg::ctx_state_s st,
    input logic [3:0]               idx);
    logic [63:0] w;
    // Words 8 to 15 carry S registers, 0 to 7 one A register each
    w = idx[3] ? st.s_reg[idx[2:0]] : {40'h0, st.a_reg[idx[2:0]]};
    if (idx == 4'h0)
    begin
      // Error type, syndrome, access kind, bank, program address
      w[`CS_E_UNC] = st.diag_type[1];
      w[`CS_E_COR] = st.diag_type[0];
      w[`CS_SYN_MSB:`CS_SYN_LSB] = st.diag_syn;
      w[`CS_RM_MSB:`CS_RM_LSB] = st.diag_rmode;
      w[`CS_BK_MSB:`CS_BK_LSB] = st.failing_location[3:0];
      w[`CS_P_MSB:`CS_P_LSB] = st.prog_addr;
    end
    else if (idx == 4'h1)
    begin
      // Middle failing address bits and base address
      w[`CS_RA_MSB:`CS_RA_LSB] = st.failing_location[19:4];
      w[`CS_BA_MSB:`CS_BA_LSB] = st.base_addr;
    end
    else if (idx == 4'h2)
    begin
      // Top failing address bits, limit and mode
      w[`CS_RP21] = st.failing_location[21];
      w[`CS_RP20] = st.failing_location[20];
      w[`CS_LA_MSB:`CS_LA_LSB] = st.limit_bound;
      w[`CS_M_MSB:`CS_M_LSB] = st.mode;
    end
    else if (idx == 4'h3)
    begin
      // Block pointer, vector length and flags
      w[`CS_XA_MSB:`CS_XA_LSB] = st.swap_block_pointer;
      w[`CS_VL_MSB:`CS_VL_LSB] = st.vector_count;
      w[`CS_F_MSB:`CS_F_LSB] = st.flags;
    end
    return w;
  endfunction

  // Load incoming word idx into the operating registers
  function automatic ctx_swap_pkg::ctx_state_s unpack_word(
    input ctx_swap_pkg::ctx_state_s st,
    input logic [3:0]               idx,
    input logic [63:0]              w);
    ctx_swap_pkg::ctx_state_s r;
    r = st;
    if (idx[3])
    begin
      r.s_reg[idx[2:0]] = w;
    end
    else
    begin
      // Diagnostic positions are output only and ignored here
      r.a_reg[idx[2:0]] = w[`CS_A_MSB:`CS_A_LSB];
      if (idx == 4'h0)
      begin
        r.prog_addr = w[`CS_P_MSB:`CS_P_LSB];
      end
      else if (idx == 4'h1)
      begin
        r.base_addr = w[`CS_BA_MSB:`CS_BA_LSB];
      end
      else if (idx == 4'h2)
      begin
        r.limit_bound = w[`CS_LA_MSB:`CS_LA_LSB];
        r.mode = w[`CS_M_MSB:`CS_M_LSB];
      end
      else if (idx == 4'h3)
      begin
        r.swap_block_pointer = w[`CS_XA_MSB:`CS_XA_LSB];
        r.vector_count = w[`CS_VL_MSB:`CS_VL_LSB];
        r.flags = w[`CS_F_MSB:`CS_F_LSB];
      end
    end
    return r;
  endfunction

  // Next-state logic: bus slave, error capture, swap sequencer
  always_comb
  begin
    s_d = s_q;
    start = swap_req;
    ev = 2'h0;
    s_d.interval_start = 1'b0;
    // Write address and data are taken in either order
    if (awvalid && s_q.awready)
    begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && s_q.wready)
    begin
      s_d.w_got = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    // Response is released by bready
    if (s_q.bvalid && bready)
    begin
      s_d.bvalid = 1'b0;
    end
    // Perform the write once both halves are held
    if (s_d.aw_got && s_d.w_got && !s_q.bvalid)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `CS_RESP_OKAY;
      unique case ({s_d.aw_addr[7:2], 2'b00})
        `CS_OFF_CTRL:
        begin
          // Bit 0 requests a swap
          if (s_d.w_strb[0] && s_d.w_data[0])
          begin
            start = 1'b1;
          end
        end
        `CS_OFF_IRQ_MASK:
        begin
          s_d.irq_mask = 2'(merge({30'h0, s_q.irq_mask},
                                  s_d.w_data, s_d.w_strb));
        end
        `CS_OFF_SWAP_PTR:
        begin
          // Bus writes to the pointer ignored while a swap runs
          if (s_q.fsm == ctx_swap_pkg::ST_IDLE)
          begin
            s_d.swap_block_pointer = 8'(merge(
              {24'h0, s_q.swap_block_pointer},
              s_d.w_data, s_d.w_strb));
          end
        end
        `CS_OFF_STATUS, `CS_OFF_IRQ_STAT, `CS_OFF_PROG_ADDR,
        `CS_OFF_MODE_FLG, `CS_OFF_VEC_CNT:
        begin
          // Read-only registers ignore writes
        end
        default:
        begin
          s_d.bresp = `CS_RESP_SLVERR;
        end
      endcase
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;
    // Read channel: one read under way at a time
    if (s_q.rvalid && rready)
    begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `CS_RESP_OKAY;
      s_d.rdata = 32'h0;
      unique case ({araddr[7:2], 2'b00})
        `CS_OFF_CTRL:
        begin
          s_d.rdata = 32'h0;
        end
        `CS_OFF_STATUS:
        begin
          s_d.rdata = {30'h0, s_q.diag_vld,
                       s_q.fsm != ctx_swap_pkg::ST_IDLE};
        end
        `CS_OFF_IRQ_STAT:
        begin
          // Reading clears; events below still win
          s_d.rdata = {30'h0, s_q.irq_stat};
          s_d.irq_stat = 2'h0;
        end
        `CS_OFF_IRQ_MASK:
        begin
          s_d.rdata = {30'h0, s_q.irq_mask};
        end
        `CS_OFF_SWAP_PTR:
        begin
          s_d.rdata = {24'h0, s_q.swap_block_pointer};
        end
        `CS_OFF_PROG_ADDR:
        begin
          s_d.rdata = {8'h0, s_q.prog_addr};
        end
        `CS_OFF_MODE_FLG:
        begin
          s_d.rdata = {19'h0, s_q.flags, s_q.mode};
        end
        `CS_OFF_VEC_CNT:
        begin
          s_d.rdata = {25'h0, s_q.vector_count};
        end
        default:
        begin
          s_d.rresp = `CS_RESP_SLVERR;
        end
      endcase
    end
    s_d.arready = !s_d.rvalid;
    // Error capture while idle; first kept, uncorrectable overrides
    if (s_q.fsm == ctx_swap_pkg::ST_IDLE && err_valid &&
        ((err_uncorr && s_q.mode[`CS_MODE_UNCORR]) ||
         (!err_uncorr && s_q.mode[`CS_MODE_CORR])) &&
        (!s_q.diag_vld || (err_uncorr && !s_q.diag_type[1])))
    begin
      s_d.diag_vld = 1'b1;
      s_d.diag_type = {err_uncorr, !err_uncorr};
      s_d.diag_syn = err_syndrome;
      // Port reports data errors only, never range errors
      s_d.diag_rmode = err_read_mode;
      s_d.failing_location = err_addr;
      ev[`CS_IRQ_DIAG] = 1'b1;
    end
    // Swap sequencer; B, T and V files live elsewhere
    unique case (s_q.fsm)
      ctx_swap_pkg::ST_IDLE:
      begin
        // Core writes only while no swap runs
        if (op_we)
        begin
          s_d = unpack_word(s_d, op_word, op_wdata);
        end
        if (start)
        begin
          // Latch the block chosen by the active pointer
          s_d.base = s_q.swap_block_pointer;
          s_d.word = 4'h0;
          s_d.mem_req = 1'b1;
          s_d.mem_we = 1'b0;
          s_d.mem_addr = {s_q.swap_block_pointer, 4'h0};
          s_d.fsm = ctx_swap_pkg::ST_RD;
        end
      end
      ctx_swap_pkg::ST_RD:
      begin
        // Fetch inactive word first, then overwrite it
        if (mem_ack)
        begin
          s_d.rbuf = mem_rdata;
          s_d.mem_we = 1'b1;
          s_d.mem_wdata = pack_word(s_q, s_q.word);
          s_d.fsm = ctx_swap_pkg::ST_WR;
        end
      end
      ctx_swap_pkg::ST_WR:
      begin
        if (mem_ack)
        begin
          // Outgoing word stored: now load the incoming one
          s_d = unpack_word(s_d, s_q.word, s_q.rbuf);
          s_d.mem_we = 1'b0;
          if (s_q.word == `CS_LAST_WORD)
          begin
            s_d.mem_req = 1'b0;
            s_d.fsm = ctx_swap_pkg::ST_DONE;
          end
          else
          begin
            s_d.word = s_q.word + 4'h1;
            s_d.mem_addr = {s_q.base, s_q.word + 4'h1};
            s_d.fsm = ctx_swap_pkg::ST_RD;
          end
        end
      end
      ctx_swap_pkg::ST_DONE:
      begin
        // Start the new interval and drop old diagnostics
        s_d.interval_start = 1'b1;
        s_d.diag_vld = 1'b0;
        s_d.diag_type = 2'h0;
        s_d.diag_syn = 8'h0;
        s_d.diag_rmode = 2'h0;
        s_d.failing_location = 22'h0;
        ev[`CS_IRQ_DONE] = 1'b1;
        s_d.fsm = ctx_swap_pkg::ST_IDLE;
      end
    endcase
    // Sticky status, set wins over the read clear
    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end
  // State register with synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= reset_state();
    end
    else
    begin
      s_q <= s_d;
    end
  end
  // Bus, memory port and operating register outputs
  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign irq = s_q.irq;
  assign mem_req = s_q.mem_req;
  assign mem_we = s_q.mem_we;
  assign mem_addr = s_q.mem_addr;
  assign mem_wdata = s_q.mem_wdata;
  assign prog_addr = s_q.prog_addr;
  assign base_addr = s_q.base_addr;
  assign limit_bound = s_q.limit_bound;
  assign mode = s_q.mode;
  assign swap_block_pointer = s_q.swap_block_pointer;
  assign vector_count = s_q.vector_count;
  assign flags = s_q.flags;
  assign a_regs = s_q.a_reg;
  assign s_regs = s_q.s_reg;
  assign busy = s_q.fsm != ctx_swap_pkg::ST_IDLE;
  assign interval_start = s_q.interval_start;
endmodule

// >>> common/ctx_swap_map.svh
// Offsets, field positions and reset values for the context swap block
// How it works
// - Context block is sixteen 64-bit words
// - Block holds P, BA, LA, mode, pointer, length, flags
// - All A and S registers saved and restored
// - Swap writes active, loads inactive, same block
// - Block chosen by pointer active at start
// - New interval starts with loaded context
// - B, T and V files are never touched
// - Diagnostics only when matching mode bit enabled
// - Word 0 position 0 uncorrectable, 1 correctable
// - Syndrome goes to word 0 positions 2-9
// - Word 0 positions 10-11 hold access kind
// - Access kind meaningless for range errors
// - Address bits 3-0 to word 0 positions 12-15
// - Address bits 19-4 to word 1 positions 0-15
// - Address bits 21,20 placed in word two
// - Positions count from the most significant bit
// - Pointer forms upper bits of 12-bit address
`ifndef CTX_SWAP_MAP_SVH
`define CTX_SWAP_MAP_SVH

// Register byte offsets
`define CS_OFF_CTRL      8'h00
`define CS_OFF_STATUS    8'h04
`define CS_OFF_IRQ_STAT  8'h08
`define CS_OFF_IRQ_MASK  8'h0c
`define CS_OFF_SWAP_PTR  8'h10
`define CS_OFF_PROG_ADDR 8'h14
`define CS_OFF_MODE_FLG  8'h18
`define CS_OFF_VEC_CNT   8'h1c

// Interrupt bits and reset values
`define CS_IRQ_DONE      0
`define CS_IRQ_DIAG      1
`define CS_IRQ_RST       2'h0
`define CS_RESP_OKAY     2'h0
`define CS_RESP_SLVERR   2'h2

// Word positions as bit numbers of weight (position p = bit 63-p)
`define CS_A_MSB   23
`define CS_A_LSB   0
`define CS_P_MSB   47
`define CS_P_LSB   24
`define CS_E_UNC   63
`define CS_E_COR   62
`define CS_SYN_MSB 61
`define CS_SYN_LSB 54
`define CS_RM_MSB  53
`define CS_RM_LSB  52
`define CS_BK_MSB  51
`define CS_BK_LSB  48
`define CS_RA_MSB  63
`define CS_RA_LSB  48
`define CS_BA_MSB  45
`define CS_BA_LSB  28
`define CS_RP21    49
`define CS_RP20    48
`define CS_LA_MSB  45
`define CS_LA_LSB  28
`define CS_M_MSB   27
`define CS_M_LSB   24
`define CS_XA_MSB  47
`define CS_XA_LSB  40
`define CS_VL_MSB  39
`define CS_VL_LSB  33
`define CS_F_MSB   32
`define CS_F_LSB   24

// Mode field bits inside the 4-bit mode register
`define CS_MODE_CORR   3
`define CS_MODE_UNCORR 1

// Last word of a context block
`define CS_LAST_WORD 4'hf

`endif

// >>> common/ctx_swap_pkg.sv
// Types shared by the context swap block
package ctx_swap_pkg;

  // Swap sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RD   = 4'b0010,
    ST_WR   = 4'b0100,
    ST_DONE = 4'b1000
  } swap_state_e;

  // Whole state of the block
  typedef struct packed {
    swap_state_e       fsm;
    logic [3:0]        word;
    logic [7:0]        base;
    logic [63:0]       rbuf;
    logic [23:0]       prog_addr;
    logic [17:0]       base_addr;
    logic [17:0]       limit_bound;
    logic [3:0]        mode;
    logic [7:0]        swap_block_pointer;
    logic [6:0]        vector_count;
    logic [8:0]        flags;
    logic [7:0][23:0]  a_reg;
    logic [7:0][63:0]  s_reg;
    logic              diag_vld;
    logic [1:0]        diag_type;
    logic [7:0]        diag_syn;
    logic [1:0]        diag_rmode;
    logic [21:0]       failing_location;
    logic              mem_req;
    logic              mem_we;
    logic [11:0]       mem_addr;
    logic [63:0]       mem_wdata;
    logic              interval_start;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [1:0]        irq_stat;
    logic [1:0]        irq_mask;
    logic              irq;
  } ctx_state_s;

endpackage

// >>> sim/context_swap_monitor.sv
// Port assertions for the context swap block
`timescale 1ns/10ps
module context_swap_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        swap_req,
  input wire logic        busy,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [11:0] mem_addr,
  input wire logic [63:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic        interval_start,
  input wire logic [7:0]  swap_block_pointer,
  input wire logic        bvalid,
  input wire logic [1:0]  bresp
);
  // One clock for all checks, quiet during reset
  default clocking dck @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Request from idle starts the sequencer
  swap_start_a: assert property (
    !busy && swap_req |=> busy)
    else $error("no swap start");
  // First read is word zero of the block
  first_read_a: assert property (
    !busy && swap_req |=> mem_req && !mem_we &&
    mem_addr == {$past(swap_block_pointer), 4'h0})
    else $error("bad first read");
  // Each read is followed by its write
  write_back_a: assert property (
    mem_req && mem_ack && !mem_we |=>
    mem_req && mem_we && $stable(mem_addr))
    else $error("no write-back");
  // Words advance one at a time through the block
  next_word_a: assert property (
    mem_req && mem_ack && mem_we && mem_addr[3:0] != 4'hf |=>
    mem_req && !mem_we && mem_addr == $past(mem_addr) + 12'h1)
    else $error("no next read");
  // Last write ends the swap
  last_word_a: assert property (
    mem_req && mem_ack && mem_we && mem_addr[3:0] == 4'hf |=>
    !mem_req ##[0:1] interval_start)
    else $error("no interval start");
  // A stalled request keeps its payload
  req_hold_a: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_we) &&
    $stable(mem_addr) && $stable(mem_wdata))
    else $error("stalled request moved");
  // Block address stays fixed for the whole swap
  block_lock_a: assert property (
    mem_req && $past(mem_req) |-> $stable(mem_addr[11:4]))
    else $error("block moved");
  // Single start pulse, then idle
  start_pulse_a: assert property (
    interval_start |-> ##[0:1] !busy ##1 !interval_start)
    else $error("bad start pulse");
  // No memory traffic while idle
  idle_quiet_a: assert property (
    !busy |-> !mem_req)
    else $error("request while idle");
  // Main scenarios reached
  cover property (interval_start);
  cover property (mem_req && !mem_ack);
  cover property (bvalid && bresp == 2'h2);
endmodule

bind context_swap context_swap_monitor context_swap_monitor_i (
  .aclk, .aresetn, .swap_req, .busy, .mem_req, .mem_we, .mem_addr,
  .mem_wdata, .mem_ack, .interval_start, .swap_block_pointer,
  .bvalid, .bresp);

// >>> sim/swap_memory_model.sv
// Behavioural central memory holding the context blocks
`timescale 1ns/10ps
module swap_memory_model (
  input  wire logic        aclk,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [11:0] mem_addr,
  input  wire logic [63:0] mem_wdata,
  output logic             mem_ack,
  output logic [63:0]      mem_rdata
);
  logic [63:0] mem [0:4095]; // Low 4096 words only
  logic [1:0]  wait_q = 2'h0; // Cycles the request has waited
  // Answer at once or after three waits
  assign mem_ack = mem_req && (!slow || wait_q == 2'h3);
  // Data valid only in the answer cycle
  assign mem_rdata = mem_ack ? mem[mem_addr] : ~mem[mem_addr];
  // Count waits and store written words
  always @(posedge aclk)
  begin
    wait_q <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
    if (mem_ack && mem_we)
      mem[mem_addr] <= mem_wdata;
  end
endmodule

// >>> sim/context_swap_bench.sv
// Self-checking bench for the context swap block
`timescale 1ns/10ps
module context_swap_bench;
  // One swap case and its outcome
  typedef struct {
    logic [3:0] md;  // Mode of the active context
    logic       unc; // Error is uncorrectable
    logic [1:0] rm;  // Access kind at the error
    logic [1:0] mk;  // Interrupt mask
    logic       ax;  // Start through the control register
    logic       sl;  // Memory stalls
    logic       cap; // Diagnostics expected in the block
  } row_s;
  row_s rows [6] = '{
    '{4'h2, 1'b1, 2'h0, 2'h3, 1'b0, 1'b0, 1'b1},
    '{4'h8, 1'b0, 2'h1, 2'h1, 1'b1, 1'b1, 1'b1},
    '{4'h8, 1'b1, 2'h2, 2'h2, 1'b0, 1'b1, 1'b0},
    '{4'h3, 1'b1, 2'h3, 2'h0, 1'b0, 1'b0, 1'b1},
    '{4'h2, 1'b0, 2'h2, 2'h2, 1'b1, 1'b0, 1'b0},
    '{4'ha, 1'b0, 2'h2, 2'h2, 1'b1, 1'b0, 1'b1}};
  logic         aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic [7:0]   awaddr = 8'h0, araddr = 8'h0, err_syndrome = 8'h0;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic         arvalid = 1'b0, rready = 1'b0, swap_req = 1'b0;
  logic         op_we = 1'b0, err_valid = 1'b0, err_uncorr = 1'b0;
  logic [31:0]  wdata = 32'h0;
  logic [3:0]   op_word = 4'h0;
  logic [63:0]  op_wdata = 64'h0;
  logic [1:0]   err_read_mode = 2'h0;
  logic [21:0]  err_addr = 22'h0;
  logic         awready, wready, bvalid, arready, rvalid, irq;
  logic         mem_req, mem_we, mem_ack, busy, interval_start;
  logic [1:0]   bresp, rresp, rsp;
  logic [31:0]  rdata, got;
  logic [11:0]  mem_addr;
  logic [63:0]  mem_wdata, mem_rdata, e;
  logic [23:0]  prog_addr;
  logic [17:0]  base_addr, limit_bound;
  logic [3:0]   mode;
  logic [7:0]   swap_block_pointer, p;
  logic [6:0]   vector_count;
  logic [8:0]   flags;
  logic [191:0] a_regs;
  logic [511:0] s_regs;
  int           mismatches = 0, samples_checked = 0;

  context_swap context_swap_i (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .irq, .swap_req,
    .op_we, .op_word, .op_wdata, .err_valid, .err_uncorr, .err_syndrome,
    .err_read_mode, .err_addr, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata, .prog_addr, .base_addr, .limit_bound, .mode,
    .swap_block_pointer, .vector_count, .flags, .a_regs, .s_regs, .busy,
    .interval_start);
  swap_memory_model swap_memory_model_i (
    .aclk, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata);

  // 125 MHz clock
  always #4 aclk = ~aclk;

  // Context word image
  function automatic logic [63:0] img(input logic [7:0] r, input int i,
                                      input logic [3:0] md,
                                      input logic [7:0] q);
    logic [23:0] a;
    a = {r, 8'h5a, 4'h0, 4'(i)};
    case (i)
      0: img = {16'h0, 16'hc0de, r, a};
      1: img = {18'h0, 10'h2a5, r, 4'h0, a};
      2: img = {18'h0, 10'h1c3, r, md, a};
      3: img = {16'h0, q, 7'h35, 9'h0a3 ^ {1'b0, r}, a};
      default: img = (i < 8) ? {40'h0, a} : {r, 12'h3c0, 4'(i), 40'h0};
    endcase
  endfunction

  // Compare and count
  task automatic chk(input logic [63:0] s, input logic [63:0] x);
    samples_checked++;
    if (s !== x)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  // Verdict and end of run
  task automatic report_and_stop;
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid && n < 50);
    chk(bvalid, 1'b1);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Register read
  task automatic rd(input logic [7:0] a);
    int n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid && n < 50);
    chk(rvalid, 1'b1);
    got = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Start a swap by pulse or by control write
  task automatic go(input logic viareg);
    if (viareg)
      wr(8'h00, 32'h1);
    else
    begin
      swap_req <= 1'b1;
      @(posedge aclk);
      swap_req <= 1'b0;
    end
  endtask

  // Wait for the new interval under a bound
  task automatic wait_done;
    int n = 0;
    while (!interval_start && n < 400)
    begin
      @(posedge aclk);
      n++;
    end
    chk(interval_start, 1'b1);
  endtask

  // Load the active context through the core port
  task automatic load(input logic [7:0] r, input logic [3:0] md,
                      input logic [7:0] q);
    for (int i = 0; i < 16; i++)
    begin
      op_we <= 1'b1;
      op_word <= 4'(i);
      op_wdata <= img(r, i, md, q);
      @(posedge aclk);
    end
    op_we <= 1'b0;
    @(posedge aclk);
  endtask

  // Place an inactive context in memory
  task automatic put(input logic [7:0] q, input logic [7:0] r,
                     input logic [7:0] nq);
    for (int i = 0; i < 16; i++)
      swap_memory_model_i.mem[{q, 4'(i)}] = img(r, i, 4'h5, nq);
  endtask

  // Operating registers hold the loaded context
  task automatic regs(input logic [7:0] r, input logic [7:0] q);
    e = img(r, 0, 4'h5, q);
    chk(prog_addr, e[47:24]);
    chk(a_regs[23:0], e[23:0]);
    rd(8'h14);
    chk(got, {8'h0, e[47:24]});
    e = img(r, 1, 4'h5, q);
    chk(base_addr, e[45:28]);
    e = img(r, 2, 4'h5, q);
    chk(limit_bound, e[45:28]);
    chk(mode, e[27:24]);
    e = img(r, 3, 4'h5, q);
    chk(swap_block_pointer, e[47:40]);
    chk(vector_count, e[39:33]);
    chk(flags, e[32:24]);
    e = img(r, 7, 4'h5, q);
    chk(a_regs[191:168], e[23:0]);
    e = img(r, 12, 4'h5, q);
    chk(s_regs[319:256], e);
  endtask

  // Watchdog
  initial
  begin
    repeat (6000) @(posedge aclk);
    mismatches++;
    report_and_stop;
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[k])
    begin
      p = 8'h10 + 8'(k);
      slow <= rows[k].sl;
      wr(8'h0c, {30'h0, rows[k].mk});
      put(p, 8'h80 + 8'(k), 8'h20 + 8'(k));
      load(8'(k), rows[k].md, p);
      err_valid <= 1'b1;
      err_uncorr <= rows[k].unc;
      err_syndrome <= 8'hc3 ^ 8'(k);
      err_read_mode <= rows[k].rm;
      err_addr <= {k[0], 21'h1a5b3};
      @(posedge aclk);
      err_valid <= 1'b0;
      go(rows[k].ax);
      wait_done;
      repeat (2) @(posedge aclk);
      chk(irq, |({rows[k].cap, 1'b1} & rows[k].mk));
      regs(8'h80 + 8'(k), 8'h20 + 8'(k));
      for (int i = 0; i < 16; i++)
      begin
        e = img(8'(k), i, rows[k].md, p);
        if (rows[k].cap && i == 0)
          e[63:48] = {rows[k].unc, !rows[k].unc, err_syndrome,
                      rows[k].rm, err_addr[3:0]};
        if (rows[k].cap && i == 1)
          e[63:48] = err_addr[19:4];
        if (rows[k].cap && i == 2)
          e[49:48] = err_addr[21:20];
        chk(swap_memory_model_i.mem[{p, 4'(i)}], e);
      end
      rd(8'h08);
      chk(got, {30'h0, rows[k].cap, 1'b1});
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
    end
    // Requests while busy are ignored
    put(8'h25, 8'h99, 8'h33);
    go(1'b0);
    wr(8'h10, 32'hee);
    chk(rsp, 2'h0);
    swap_req <= 1'b1;
    op_we <= 1'b1;
    op_word <= 4'h0;
    @(posedge aclk);
    swap_req <= 1'b0;
    op_we <= 1'b0;
    wait_done;
    repeat (4) @(posedge aclk);
    chk(busy, 1'b0);
    regs(8'h99, 8'h33);
    // Read-only and unmapped places
    wr(8'h14, 32'hffffffff);
    rd(8'h14);
    chk(got, {8'h0, 24'hc0de99});
    wr(8'h40, 32'h1);
    chk(rsp, 2'h2);
    rd(8'h44);
    chk(rsp, 2'h2);
    chk(got, 32'h0);
    wr(8'h10, 32'h42);
    rd(8'h10);
    chk(got, 32'h42);
    chk(swap_block_pointer, 8'h42);
    // Reset in the middle of a swap
    go(1'b0);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({awready, wready, arready, mem_req, busy, irq}, 6'h38);
    chk(swap_block_pointer, 8'h0);
    chk(prog_addr, 24'h0);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h0c);
    chk(got, 32'h0);
    report_and_stop;
  end
endmodule
